// File: rtl/pvc_pkg.sv
package pvc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_DIG_CTRL = 5'h10; // PLL behaviour in power down
  localparam logic [4:0] REG_SYM_ERR = 5'h15; // Symbol error frame count
  localparam logic [4:0] REG_STRAP_OVR = 5'h16; // Strap override control
  localparam logic [4:0] REG_STRAP_STAT = 5'h17; // Strap value status
  localparam logic [4:0] REG_EXP_CTRL = 5'h18; // Expanded power control
  localparam logic [4:0] REG_INT_CTRL = 5'h1B; // Interrupt enables and flags

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] SYM_ERR_RST = 16'h0000;
  localparam logic [15:0] STRAP_OVR_RST = 16'h0002;
  localparam logic [15:0] STRAP_OVR_WMASK = 16'hFBFF; // Bit 10 reads zero
  localparam logic [15:0] EXP_CTRL_RST = 16'h0800;
  localparam logic [15:0] DIG_CTRL_RST = 16'h0000;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] INT_FLAG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OVR_B2B_BIT = 6;
  localparam int OVR_NAND_BIT = 5;
  localparam int OVR_RMII_BIT = 1;
  localparam int STAT_ADDR_LSB = 13;
  localparam int STAT_RMII_BIT = 1;
  localparam int EXP_PD_OFF_BIT = 11;
  localparam int DIG_PLL_BIT = 4;
  localparam int INT_EN_LSB = 8;
  localparam logic [2:0] ADDR_STRAP_LOW = 3'h0; // Strap pin low
  localparam logic [2:0] ADDR_STRAP_HIGH = 3'h3; // Strap pin high

  // ----------------------------------------------------------------
  // Management frame timing, in link clock edges
  // ----------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0C; // Start bit 2, opcode, addresses
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] STRAP_SETTLE = 2'h2; // Cycles after release

  // Frame decoder states
  typedef enum logic [3:0] {
    ST_PRE = 4'h1,
    ST_HDR = 4'h2,
    ST_TA = 4'h4,
    ST_DATA = 4'h8
  } pvc_state_t;

endpackage

// File: rtl/pvc_mgmt_if.sv
`timescale 1ns/10ps
interface pvc_mgmt_if;
  logic rdReq; // One cycle read request
  logic wrReq; // One cycle write request
  logic [4:0] regAddr; // Register index
  logic [15:0] wrData; // Write value
  logic [15:0] rdData; // Read value, valid the cycle after rdReq
  modport slave(output rdReq, output wrReq, output regAddr, output wrData, input rdData);
  modport bank(input rdReq, input wrReq, input regAddr, input wrData, output rdData);
endinterface

// File: rtl/pvc_mdio_slave.sv
`timescale 1ns/10ps
module pvc_mdio_slave import pvc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstSyncN,
  // Management link pins
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN,
  // Own management address
  input wire logic [4:0] phyAddr,
  // Register side
  pvc_mgmt_if.slave mgmt
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic mdcMeta, mdcSync, mdcLast; // Link clock chain
  logic mdioMeta, mdioSync; // Data chain
  logic mdcRise; // Sampling point

  // Two stages before any use
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      mdcMeta <= 1'b0;
      mdcSync <= 1'b0;
      mdcLast <= 1'b0;
      mdioMeta <= 1'b1;
      mdioSync <= 1'b1;
    end else begin
      mdcMeta <= mdc;
      mdcSync <= mdcMeta;
      mdcLast <= mdcSync;
      mdioMeta <= mdioIn;
      mdioSync <= mdioMeta;
    end
  end

  assign mdcRise = mdcSync & ~mdcLast;

  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  pvc_state_t state, next_state;
  logic [5:0] preCnt, next_preCnt; // Consecutive ones seen
  logic [4:0] bitCnt, next_bitCnt; // Bits within a field
  logic [12:0] hdr, next_hdr; // Start, opcode, addresses
  logic [12:0] hdrNew; // Header with current bit
  logic [15:0] shReg, next_shReg; // Data in or out
  logic isRead, next_isRead;
  logic oeN, next_oeN;
  logic rdReq, next_rdReq;
  logic wrReq, next_wrReq;
  logic [4:0] addrReg, next_addrReg;

  // Next values on each sampled link edge
  always_comb begin
    next_state = state;
    next_preCnt = preCnt;
    next_bitCnt = bitCnt;
    next_hdr = hdr;
    next_shReg = shReg;
    next_isRead = isRead;
    next_oeN = oeN;
    next_rdReq = 1'b0;
    next_wrReq = 1'b0;
    next_addrReg = addrReg;
    hdrNew = {hdr[11:0], mdioSync};
    if (mdcRise) begin
      case (state)
        ST_PRE: begin
          // Ones count up, a zero after a full preamble starts a frame
          if (mdioSync) begin
            if (preCnt != PREAMBLE_LEN) begin
              next_preCnt = preCnt + 6'h01;
            end
          end else begin
            if (preCnt == PREAMBLE_LEN) begin
              next_state = ST_HDR;
              next_bitCnt = 5'h00;
            end
            next_preCnt = 6'h00;
          end
        end
        ST_HDR: begin
          next_hdr = hdrNew;
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == HDR_LAST) begin
            next_bitCnt = 5'h00;
            next_state = ST_PRE;
            // Own address and a known opcode only
            if (hdrNew[12] && hdrNew[9:5] == phyAddr &&
                (hdrNew[11:10] == OP_READ || hdrNew[11:10] == OP_WRITE)) begin
              next_state = ST_TA;
              next_isRead = (hdrNew[11:10] == OP_READ);
              next_rdReq = (hdrNew[11:10] == OP_READ);
              next_addrReg = hdrNew[4:0];
            end
          end
        end
        ST_TA: begin
          if (bitCnt == 5'h00) begin
            next_bitCnt = 5'h01;
            // Second turnaround bit driven low
            if (isRead) begin
              next_oeN = 1'b0;
              next_shReg = 16'h0000;
            end
          end else begin
            next_bitCnt = 5'h00;
            next_state = ST_DATA;
            if (isRead) begin
              next_shReg = mgmt.rdData;
            end
          end
        end
        ST_DATA: begin
          next_bitCnt = bitCnt + 5'h01;
          next_shReg = {shReg[14:0], isRead ? 1'b0 : mdioSync};
          if (bitCnt == DATA_LAST) begin
            // Release the line, or hand the word over
            next_state = ST_PRE;
            next_bitCnt = 5'h00;
            next_oeN = 1'b1;
            next_wrReq = ~isRead;
          end
        end
        default: begin
          next_state = ST_PRE;
        end
      endcase
    end
  end

  // Decoder registers
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state <= ST_PRE;
      preCnt <= 6'h00;
      bitCnt <= 5'h00;
      hdr <= 13'h0000;
      shReg <= 16'h0000;
      isRead <= 1'b0;
      oeN <= 1'b1;
      rdReq <= 1'b0;
      wrReq <= 1'b0;
      addrReg <= 5'h00;
    end else begin
      state <= next_state;
      preCnt <= next_preCnt;
      bitCnt <= next_bitCnt;
      hdr <= next_hdr;
      shReg <= next_shReg;
      isRead <= next_isRead;
      oeN <= next_oeN;
      rdReq <= next_rdReq;
      wrReq <= next_wrReq;
      addrReg <= next_addrReg;
    end
  end

  assign mdioOut = shReg[15];
  assign mdioOeN = oeN;
  assign mgmt.rdReq = rdReq;
  assign mgmt.wrReq = wrReq;
  assign mgmt.regAddr = addrReg;
  assign mgmt.wrData = shReg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_turnaround_low: assert property (@(posedge clk) disable iff (!rstSyncN)
    (state == ST_TA && !oeN) |-> !mdioOut) else $error("turnaround bit not low");
  a_drive_only_read: assert property (@(posedge clk) disable iff (!rstSyncN)
    !oeN |-> isRead) else $error("line driven during a write");

endmodule

// File: rtl/pvc_vendor_regs.sv
`timescale 1ns/10ps
// Contract
// - Symbol error frame count, cleared on read
// - Back-to-back needs RMII override also set
// - NAND tree override bit, reset zero
// - RMII override resets to one, writable
// - Address strap reports zero or three only
// - RMII strap status bit reads strap
// - Power-down disable bit, resets to one
// - Jabber interrupt enable, reset zero
// - Receive error interrupt enable, reset zero
// - Page received interrupt enable, reset zero
// - Parallel detect fault enable, reset zero
// - Event flags read-only, cleared on read
// - PLL off control in power down
module pvc_vendor_regs import pvc_pkg::*; #(
  parameter int CNT_W = 16,
  parameter int FLAG_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Management link
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOeN,
  // Power-up straps
  input wire logic addrStrap,
  input wire logic rmiiStrap,
  // Core events, same clock
  input wire logic symErrFrame,
  input wire logic [FLAG_W-1:0] intEvent,
  // Mode controls to the core
  output logic rmiiMode,
  output logic backToBackMode,
  output logic nandTreeMode,
  output logic energyDetectPowerDownOff,
  output logic pllOffInPowerDown,
  output logic interruptN
);

  // Sizes the register layout relies on
  if (CNT_W != 16 || FLAG_W != 8) begin : g_check
    $error("counter must be 16 bits and flags 8 bits");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe; // Release chain
  logic rstSyncN; // Released reset

  // Assert at once, release after two edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // ----------------------------------------------------------------
  // Management link
  // ----------------------------------------------------------------
  pvc_mgmt_if mgmt ();
  logic [2:0] addrStrapVal; // Captured address

  pvc_mdio_slave i_pvc_mdio_slave (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOeN(mdioOeN),
    .phyAddr({2'h0, addrStrapVal}),
    .mgmt(mgmt.slave)
  );

  // Read and write strobes for one register
  function automatic logic hit(input logic req, input logic [4:0] a, input logic [4:0] r);
    hit = req && (a == r);
  endfunction

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [1:0] strapMeta, strapSync; // Pin synchronisers
  logic [1:0] strapCnt, next_strapCnt; // Settle count
  logic [2:0] next_addrStrapVal;
  logic rmiiStrapVal, next_rmiiStrapVal;

  // Straps are pins, two stages first
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      strapMeta <= 2'h0;
      strapSync <= 2'h0;
    end else begin
      strapMeta <= {addrStrap, rmiiStrap};
      strapSync <= strapMeta;
    end
  end

  // Latch once the chain has settled
  always_comb begin
    next_strapCnt = strapCnt;
    next_addrStrapVal = addrStrapVal;
    next_rmiiStrapVal = rmiiStrapVal;
    if (strapCnt != 2'h3) begin
      next_strapCnt = strapCnt + 2'h1;
    end
    if (strapCnt == STRAP_SETTLE) begin
      next_addrStrapVal = strapSync[1] ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
      next_rmiiStrapVal = strapSync[0];
    end
  end

  // Strap registers
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      strapCnt <= 2'h0;
      addrStrapVal <= ADDR_STRAP_LOW;
      rmiiStrapVal <= 1'b0;
    end else begin
      strapCnt <= next_strapCnt;
      addrStrapVal <= next_addrStrapVal;
      rmiiStrapVal <= next_rmiiStrapVal;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [15:0] symErrCnt, next_symErrCnt; // Error frame count
  logic [15:0] strapOvr, next_strapOvr; // Override control
  logic [15:0] expCtrl, next_expCtrl; // Expanded control
  logic [15:0] digCtrl, next_digCtrl; // PLL control word
  logic [7:0] intEn, next_intEn; // Interrupt enables
  logic [7:0] intFlag, next_intFlag; // Sticky event flags
  logic [15:0] rdData, next_rdData; // Read value
  logic rdCnt, rdInt; // Clear-on-read strobes
  logic next_rmiiMode, next_b2bMode, next_irqN;

  assign rdCnt = hit(mgmt.rdReq, mgmt.regAddr, REG_SYM_ERR);
  assign rdInt = hit(mgmt.rdReq, mgmt.regAddr, REG_INT_CTRL);

  // Read view of every register
  function automatic logic [15:0] readMux(input logic [4:0] a);
    case (a)
      REG_SYM_ERR: readMux = symErrCnt;
      REG_STRAP_OVR: readMux = strapOvr & STRAP_OVR_WMASK;
      REG_STRAP_STAT: begin
        readMux = 16'h0000;
        readMux[STAT_ADDR_LSB +: 3] = addrStrapVal;
        readMux[STAT_RMII_BIT] = rmiiStrapVal;
      end
      REG_EXP_CTRL: readMux = expCtrl;
      REG_DIG_CTRL: readMux = digCtrl;
      REG_INT_CTRL: readMux = {intEn, intFlag};
      default: readMux = 16'h0000; // Unmapped
    endcase
  endfunction

  // Register updates
  always_comb begin
    next_symErrCnt = symErrCnt;
    next_strapOvr = strapOvr;
    next_expCtrl = expCtrl;
    next_digCtrl = digCtrl;
    next_intEn = intEn;
    next_rdData = rdData;
    // Count saturates, a new frame beats the read clear
    if (rdCnt) begin
      next_symErrCnt = 16'h0000;
    end
    if (symErrFrame) begin
      if (rdCnt) begin
        next_symErrCnt = 16'h0001;
      end else if (symErrCnt != 16'hFFFF) begin
        next_symErrCnt = symErrCnt + 16'h0001;
      end
    end
    // Flags clear on read, events win
    next_intFlag = (rdInt ? INT_FLAG_RST : intFlag) | intEvent;
    // Software writes
    if (hit(mgmt.wrReq, mgmt.regAddr, REG_STRAP_OVR)) begin
      next_strapOvr = mgmt.wrData & STRAP_OVR_WMASK;
    end
    if (hit(mgmt.wrReq, mgmt.regAddr, REG_EXP_CTRL)) begin
      next_expCtrl = mgmt.wrData;
    end
    if (hit(mgmt.wrReq, mgmt.regAddr, REG_DIG_CTRL)) begin
      next_digCtrl = mgmt.wrData;
    end
    if (hit(mgmt.wrReq, mgmt.regAddr, REG_INT_CTRL)) begin
      next_intEn = mgmt.wrData[15:INT_EN_LSB];
    end
    if (mgmt.rdReq) begin
      next_rdData = readMux(mgmt.regAddr);
    end
    // Mode outputs
    next_rmiiMode = next_strapOvr[OVR_RMII_BIT] | rmiiStrapVal;
    next_b2bMode = next_strapOvr[OVR_B2B_BIT] & next_strapOvr[OVR_RMII_BIT];
    next_irqN = ~|(intFlag & intEn);
  end

  // Bank registers
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      symErrCnt <= SYM_ERR_RST;
      strapOvr <= STRAP_OVR_RST;
      expCtrl <= EXP_CTRL_RST;
      digCtrl <= DIG_CTRL_RST;
      intEn <= INT_EN_RST;
      intFlag <= INT_FLAG_RST;
      rdData <= 16'h0000;
      rmiiMode <= 1'b1;
      backToBackMode <= 1'b0;
      interruptN <= 1'b1;
    end else begin
      symErrCnt <= next_symErrCnt;
      strapOvr <= next_strapOvr;
      expCtrl <= next_expCtrl;
      digCtrl <= next_digCtrl;
      intEn <= next_intEn;
      intFlag <= next_intFlag;
      rdData <= next_rdData;
      rmiiMode <= next_rmiiMode;
      backToBackMode <= next_b2bMode;
      interruptN <= next_irqN;
    end
  end

  assign mgmt.rdData = rdData;
  assign nandTreeMode = strapOvr[OVR_NAND_BIT];
  assign energyDetectPowerDownOff = expCtrl[EXP_PD_OFF_BIT];
  assign pllOffInPowerDown = digCtrl[DIG_PLL_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  a_count_clears: assert property (
    (rdCnt && !symErrFrame) |=> symErrCnt == 16'h0000) else $error("count not cleared");
  a_count_steps: assert property (
    (!rdCnt && symErrFrame && symErrCnt != 16'hFFFF) |=> symErrCnt == $past(symErrCnt) + 16'h0001)
    else $error("count did not step");
  a_b2b_needs_rmii: assert property (
    backToBackMode |-> (strapOvr[OVR_RMII_BIT] && rmiiMode)) else $error("b2b without rmii");
  a_nand_follows: assert property (
    hit(mgmt.wrReq, mgmt.regAddr, REG_STRAP_OVR) |=> nandTreeMode == $past(mgmt.wrData[OVR_NAND_BIT]))
    else $error("nand tree override wrong");
  a_reset_values: assert property (
    strapCnt == 2'h0 |-> (strapOvr[OVR_RMII_BIT] && energyDetectPowerDownOff &&
    intEn == 8'h00 && !nandTreeMode))
    else $error("bad reset value");
  a_addr_legal: assert property (
    strapCnt == 2'h3 |-> (addrStrapVal == ADDR_STRAP_LOW || addrStrapVal == ADDR_STRAP_HIGH))
    else $error("illegal strap address");
  a_pd_off_write: assert property (
    hit(mgmt.wrReq, mgmt.regAddr, REG_EXP_CTRL) |=>
    energyDetectPowerDownOff == $past(mgmt.wrData[EXP_PD_OFF_BIT]))
    else $error("power-down disable bit wrong");
  a_flag_sticky: assert property (
    (intEvent[7] && !rdInt) ##1 !rdInt |=> intFlag[7]) else $error("jabber flag lost");
  a_flag_read_clear: assert property (
    (rdInt && intEvent == 8'h00) |=> intFlag == 8'h00) else $error("flags not cleared");
  a_irq_enabled: assert property (
    (|(intFlag & intEn)) |=> !interruptN) else $error("interrupt not raised");
  a_irq_quiet: assert property (
    (intFlag & intEn) == 8'h00 |=> interruptN) else $error("spurious interrupt");
  a_pll_write: assert property (
    hit(mgmt.wrReq, mgmt.regAddr, REG_DIG_CTRL) |=>
    pllOffInPowerDown == $past(mgmt.wrData[DIG_PLL_BIT]))
    else $error("pll control wrong");
  a_stat_reserved: assert property (
    (mgmt.rdReq && mgmt.regAddr == REG_STRAP_STAT) |=> rdData[12:2] == 11'h000 && !rdData[0])
    else $error("reserved status bits set");

endmodule

// File: tb/pvc_mdio_master.sv
`timescale 1ns/10ps
module pvc_mdio_master (
  // Core clock that paces the link
  input wire logic clk,
  // Management link pins
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOeN
);
  // ----------------------------------------------------------------
  // Shared data line
  // ----------------------------------------------------------------
  logic drvEn; // Master drives the line
  logic drvBit; // Bit the master drives

  // Device, master, else the pull-up level
  assign mdioIn = !mdioOeN ? mdioOut : (drvEn ? drvBit : 1'b1);

  // Link idle at time zero
  initial begin
    mdc = 1'b0;
    drvEn = 1'b0;
    drvBit = 1'b1;
  end

  // ----------------------------------------------------------------
  // One whole frame, own preamble included
  // ----------------------------------------------------------------
  // Returns the last 18 samples: two turnaround bits, then the data word
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [17:0] rd);
    logic [63:0] bits;
    logic isRead;
    isRead = (op == 2'h2);
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, (isRead ? 2'b11 : 2'b10), wd};
    rd = '0;
    for (int i = 63; i >= 0; i--) begin
      @(negedge clk);
      mdc = 1'b0; // Bit changes while the link clock is low
      drvEn = !(isRead && i < 18); // Released for turnaround and read data
      drvBit = bits[i];
      repeat (10) @(negedge clk);
      mdc = 1'b1;
      rd = {rd[16:0], mdioIn}; // Sampled at the rise
      repeat (9) @(negedge clk);
    end
    @(negedge clk);
    mdc = 1'b0; // Link clock stands still between frames
    drvEn = 1'b0;
    repeat (10) @(negedge clk);
  endtask
endmodule

// File: tb/phy_vendor_control_registers_tb.sv
`timescale 1ns/10ps
module phy_vendor_control_registers_tb;
  import pvc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rstn, mdc, mdioIn, mdioOut, mdioOeN; // Clock, reset, link
  logic addrStrap, rmiiStrap, symErrFrame; // Straps and counter event
  logic [7:0] intEvent; // Core event pulses
  logic rmiiMode, backToBackMode, nandTreeMode; // Mode outputs
  logic energyDetectPowerDownOff, pllOffInPowerDown, interruptN; // Power and interrupt
  logic [17:0] raw; // Samples of the last frame
  int errTotal = 0; // Mismatches
  int nCompared = 0; // Comparisons
  logic [4:0] ownAddr = 5'h03; // Management address, follows the address strap

  // ----------------------------------------------------------------
  // Design and link partner
  // ----------------------------------------------------------------
  pvc_vendor_regs i_pvc_vendor_regs (.clk(clk), .rstn(rstn), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOeN(mdioOeN), .addrStrap(addrStrap), .rmiiStrap(rmiiStrap),
    .symErrFrame(symErrFrame), .intEvent(intEvent), .rmiiMode(rmiiMode),
    .backToBackMode(backToBackMode), .nandTreeMode(nandTreeMode),
    .energyDetectPowerDownOff(energyDetectPowerDownOff),
    .pllOffInPowerDown(pllOffInPowerDown), .interruptN(interruptN));
  pvc_mdio_master i_pvc_mdio_master (.clk(clk), .mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOeN(mdioOeN));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Verdict and end of run
  task automatic closeOut();
    if (errTotal == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare one value
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Register read with turnaround check
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    i_pvc_mdio_master.frame(OP_READ, ownAddr, ra, 16'h0000, raw);
    check({14'h0000, raw[17:16]}, 16'h0002); // Released, then driven low
    check(raw[15:0], exp);
  endtask

  // Register write
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    i_pvc_mdio_master.frame(OP_WRITE, ownAddr, ra, wd, raw);
  endtask

  // Mode outputs: rmii, back-to-back, nand, power-down off, pll off, irq
  task automatic pins(input logic [5:0] exp);
    check({10'h000, rmiiMode, backToBackMode, nandTreeMode, energyDetectPowerDownOff,
      pllOffInPowerDown, interruptN}, {10'h000, exp});
  endtask

  // One-cycle event pulse
  task automatic pulse(input logic s, input logic [7:0] ev);
    @(negedge clk);
    symErrFrame = s;
    intEvent = ev;
    @(negedge clk);
    symErrFrame = 1'b0;
    intEvent = 8'h00;
  endtask

  // Bounded wait for the interrupt level
  task automatic waitIrq(input logic lvl);
    int n;
    n = 0;
    while (interruptN !== lvl && n < 8) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, interruptN}, {15'h0000, lvl});
    // Bound used up: already counted, end the run
    if (interruptN !== lvl) begin
      closeOut();
    end
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  initial begin
    #360_000;
    errTotal++;
    closeOut();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    addrStrap = 1'b1;
    rmiiStrap = 1'b1;
    symErrFrame = 1'b0;
    intEvent = 8'h00;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (20) @(negedge clk);
    // Reset values
    pins(6'b100101);
    rd(REG_SYM_ERR, 16'h0000);
    rd(REG_STRAP_OVR, 16'h0002);
    rd(REG_STRAP_STAT, 16'h6002);
    rd(REG_EXP_CTRL, 16'h0800);
    rd(REG_INT_CTRL, 16'h0000);
    rd(REG_DIG_CTRL, 16'h0000);
    // Frames to another address and a bad opcode are ignored
    i_pvc_mdio_master.frame(OP_READ, 5'h00, REG_STRAP_OVR, 16'h0000, raw);
    check(raw[15:0], 16'hFFFF); // Line left to the pull-up
    i_pvc_mdio_master.frame(OP_WRITE, 5'h00, REG_EXP_CTRL, 16'h0000, raw);
    i_pvc_mdio_master.frame(2'h3, ownAddr, REG_EXP_CTRL, 16'h0000, raw);
    rd(REG_EXP_CTRL, 16'h0800);
    // Strap overrides
    wr(REG_STRAP_OVR, 16'h0062);
    pins(6'b111101);
    wr(REG_STRAP_OVR, 16'h0040);
    pins(6'b100101);
    wr(REG_STRAP_OVR, 16'hFFFF);
    rd(REG_STRAP_OVR, 16'hFBFF);
    wr(REG_STRAP_OVR, 16'h0000);
    rd(REG_STRAP_OVR, 16'h0000);
    // Power controls
    wr(REG_EXP_CTRL, 16'h0000);
    wr(REG_DIG_CTRL, 16'h0010);
    pins(6'b100011);
    rd(REG_EXP_CTRL, 16'h0000);
    rd(REG_DIG_CTRL, 16'h0010);
    // Symbol error count clears when read
    repeat (3) pulse(1'b1, 8'h00);
    rd(REG_SYM_ERR, 16'h0003);
    rd(REG_SYM_ERR, 16'h0000);
    // Each upper enable against its own event
    for (int b = 4; b < 8; b++) begin
      // Ones written to the flag half must not set any flag
      wr(REG_INT_CTRL, (16'h0001 << (b + 8)) | 16'h00FF);
      pulse(1'b0, 8'h01 << b);
      waitIrq(1'b0);
      rd(REG_INT_CTRL, (16'h0001 << (b + 8)) | (16'h0001 << b));
      waitIrq(1'b1);
    end
    // Event whose enable is off leaves the output high
    pulse(1'b0, 8'h01);
    repeat (8) @(negedge clk);
    pins(6'b100011);
    rd(REG_INT_CTRL, 16'h8001);
    rd(REG_INT_CTRL, 16'h8000);
    // Unmapped register
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    // Second reset with both straps low: address zero, no strapped RMII
    @(negedge clk);
    rstn = 1'b0;
    addrStrap = 1'b0;
    rmiiStrap = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    ownAddr = 5'h00;
    repeat (20) @(negedge clk);
    pins(6'b100101);
    rd(REG_STRAP_STAT, 16'h0000);
    i_pvc_mdio_master.frame(OP_READ, 5'h03, REG_STRAP_STAT, 16'h0000, raw);
    check(raw[15:0], 16'hFFFF); // Old address no longer answers
    wr(REG_STRAP_OVR, 16'h0000);
    pins(6'b000101);
    closeOut();
  end
endmodule
